//--- src/dcs_cmd_select.sv
// Run command and frequency reference source selection of the drive
`timescale 1ns/100ps
`default_nettype none
`include "dcs_drive_regs.svh"
module dcs_cmd_select #(
	parameter int N_TERM = 6
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Mode and pattern
	input wire logic i_control_mode_sel,
	input wire logic [4:0] i_vhz_pattern_sel,
	// Source selection
	input wire dcs_pkg::dcs_run_src_e i_main_run_source,
	input wire dcs_pkg::dcs_run_src_e i_alt_run_source,
	input wire logic [2:0] i_main_freq_source,
	input wire logic [2:0] i_alt_freq_source,
	// Limits, ramps and jog
	input wire dcs_pkg::dcs_freq_t i_freq_upper_limit,
	input wire dcs_pkg::dcs_freq_t i_freq_lower_limit,
	input wire dcs_pkg::dcs_freq_t i_motor_rated_freq,
	input wire dcs_pkg::dcs_time_t i_accel_time_one,
	input wire dcs_pkg::dcs_time_t i_decel_time_one,
	input wire dcs_pkg::dcs_time_t i_accel_time_two,
	input wire dcs_pkg::dcs_time_t i_decel_time_two,
	input wire dcs_pkg::dcs_freq_t i_jog_frequency,
	input wire logic [7:0] i_jog_accel_time,
	input wire logic [7:0] i_jog_decel_time,
	// Terminal control
	input wire logic [1:0] i_terminal_op_mode,
	input wire logic i_reverse_prohibit,
	input wire logic [N_TERM-1:0][4:0] i_input_function_codes,
	input wire logic [N_TERM-1:0] i_terminals,
	// Keypad and serial link
	input wire logic i_key_run,
	input wire logic i_key_stop,
	input wire logic i_key_reverse,
	input wire logic i_comm_run,
	input wire logic i_comm_reverse,
	// Frequency references
	input wire dcs_pkg::dcs_freq_t i_ref_keypad,
	input wire dcs_pkg::dcs_freq_t i_ref_pot,
	input wire dcs_pkg::dcs_freq_t i_ref_analog,
	input wire dcs_pkg::dcs_freq_t i_ref_updown,
	input wire dcs_pkg::dcs_freq_t i_ref_comm,
	input wire dcs_pkg::dcs_freq_t [`DCS_PRESETS-1:0] i_preset_freqs,
	// Mode status
	output logic o_vector_mode,
	output logic [4:0] o_vhz_pattern,
	output logic o_vhz_custom,
	output logic o_cfg_error,
	output var dcs_pkg::dcs_run_src_e o_run_source,
	output logic [2:0] o_freq_source,
	// Run command
	output logic o_run,
	output logic o_reverse,
	output logic o_jog_active,
	output logic o_emergency_stop,
	output logic o_accel_set_two,
	// Frequency and ramps
	output dcs_pkg::dcs_freq_t o_freq_cmd,
	output logic o_zero_stop,
	output dcs_pkg::dcs_time_t o_accel_ramp,
	output dcs_pkg::dcs_time_t o_decel_ramp
);
	import dcs_pkg::*;

	logic [N_TERM-1:0] term_meta;
	logic [N_TERM-1:0] term_sync;
	logic [N_TERM-1:0] term_prev;
	logic [N_TERM-1:0] fn_ok;
	logic [N_TERM-1:0] code_bad;
	logic [`DCS_PRESET_BITS-1:0] preset_on;
	logic [`DCS_PRESET_BITS-1:0] preset_used;
	logic three_wire, t_fwd, t_rev, j_fwd, j_rev, t_acc2;
	logic run_sel_on, run_sel_used, frq_sel_on, frq_sel_used;
	logic term_fwd, term_rev, term_any, cmd_run, cmd_rev, jog_now, want_rev;
	logic next_run, estop, tw_edge;
	dcs_run_src_e run_src;
	logic [2:0] frq_src;
	dcs_latch_e tw_state, key_state;
	dcs_freq_t ref_sel, jog_eff, next_freq_req;
	logic [7:0] jog_acc_eff, jog_dec_eff;

	dcs_lim_if u_lim_if();

	// Any terminal whose usable function matches and whose level is on
	function automatic logic fn_hit(input logic [4:0] fn, input logic [N_TERM-1:0] lvl,
		input logic [N_TERM-1:0] ok, input logic [N_TERM-1:0][4:0] codes);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < N_TERM; k++) begin
			if (ok[k] && lvl[k] && codes[k] == fn) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// Two stages before any decode; the third copy feeds the run edge only
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			term_meta <= '0;
			term_sync <= '0;
			term_prev <= '0;
		end else begin
			term_meta <= i_terminals;
			term_sync <= term_meta;
			term_prev <= term_sync;
		end
	end

	assign three_wire = (i_terminal_op_mode == DCS_TM_THREE_WIRE);

	for (genvar g = 0; g < N_TERM; g++) begin : g_fn
		assign code_bad[g] = (i_input_function_codes[g] > `DCS_FN_LIMIT) ||
			(i_input_function_codes[g] == `DCS_FN_COUNTER && g != N_TERM - 1);
		assign fn_ok[g] = !code_bad[g] && !(three_wire && g < `DCS_3W_TERMS);
	end

	assign t_fwd = fn_hit(`DCS_FN_FWD, term_sync, fn_ok, i_input_function_codes);
	assign t_rev = fn_hit(`DCS_FN_REV, term_sync, fn_ok, i_input_function_codes);
	assign j_fwd = fn_hit(`DCS_FN_JOG_FWD, term_sync, fn_ok, i_input_function_codes);
	assign j_rev = fn_hit(`DCS_FN_JOG_REV, term_sync, fn_ok, i_input_function_codes);
	assign t_acc2 = fn_hit(`DCS_FN_ACC_SET2, term_sync, fn_ok, i_input_function_codes);
	assign run_sel_on = fn_hit(`DCS_FN_RUN_SRC, term_sync, fn_ok, i_input_function_codes);
	assign run_sel_used = fn_hit(`DCS_FN_RUN_SRC, '1, fn_ok, i_input_function_codes);
	assign frq_sel_on = fn_hit(`DCS_FN_FRQ_SRC, term_sync, fn_ok, i_input_function_codes);
	assign frq_sel_used = fn_hit(`DCS_FN_FRQ_SRC, '1, fn_ok, i_input_function_codes);

	for (genvar p = 0; p < `DCS_PRESET_BITS; p++) begin : g_preset
		assign preset_on[p] = fn_hit(`DCS_FN_PRESET0 + 5'(p), term_sync, fn_ok,
			i_input_function_codes);
		assign preset_used[p] = fn_hit(`DCS_FN_PRESET0 + 5'(p), '1, fn_ok,
			i_input_function_codes);
	end

	// With no selector terminal assigned the main selectors govern
	assign run_src = (run_sel_used && !run_sel_on) ? i_alt_run_source : i_main_run_source;
	assign frq_src = (frq_sel_used && !frq_sel_on) ? i_alt_freq_source
		: i_main_freq_source;

	assign tw_edge = term_sync[`DCS_3W_RUN_T] && !term_prev[`DCS_3W_RUN_T];

	// Three-wire: run button latches, opening the stop contact releases
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			tw_state <= DCS_LT_STOP;
		end else begin
			unique case (tw_state)
				DCS_LT_STOP: begin
					if (three_wire && run_src == DCS_RS_TERM && !estop && tw_edge &&
						term_sync[`DCS_3W_STOP_T]) begin
						tw_state <= DCS_LT_RUN;
					end
				end
				DCS_LT_RUN: begin
					if (!three_wire || run_src != DCS_RS_TERM || estop ||
						!term_sync[`DCS_3W_STOP_T]) begin
						tw_state <= DCS_LT_STOP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			key_state <= DCS_LT_STOP;
		end else begin
			unique case (key_state)
				DCS_LT_STOP: begin
					if (run_src == DCS_RS_KEYPAD && i_key_run && !i_key_stop) begin
						key_state <= DCS_LT_RUN;
					end
				end
				DCS_LT_RUN: begin
					if (run_src != DCS_RS_KEYPAD || i_key_stop) begin
						key_state <= DCS_LT_STOP;
					end
				end
			endcase
		end
	end

	always_comb begin
		term_fwd = 1'b0;
		term_rev = 1'b0;
		unique case (i_terminal_op_mode)
			DCS_TM_FWD_REV: begin
				term_fwd = t_fwd && !t_rev;
				term_rev = t_rev && !t_fwd;
			end
			DCS_TM_RUN_DIR: begin
				term_fwd = t_fwd && !t_rev;
				term_rev = t_fwd && t_rev;
			end
			DCS_TM_THREE_WIRE: begin
				term_fwd = tw_state == DCS_LT_RUN && !term_sync[`DCS_3W_DIR_T];
				term_rev = tw_state == DCS_LT_RUN && term_sync[`DCS_3W_DIR_T];
			end
			default: begin
			end
		endcase
	end

	// Stop key latches until every terminal run request has been let go
	assign term_any = term_fwd || term_rev || j_fwd || j_rev;
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			estop <= 1'b0;
		end else if (run_src == DCS_RS_TERM && i_key_stop) begin
			estop <= 1'b1;
		end else if (!term_any || run_src != DCS_RS_TERM) begin
			estop <= 1'b0;
		end
	end

	always_comb begin
		cmd_run = 1'b0;
		cmd_rev = 1'b0;
		unique case (run_src)
			DCS_RS_KEYPAD: begin
				cmd_run = key_state == DCS_LT_RUN;
				cmd_rev = i_key_reverse;
			end
			DCS_RS_TERM: begin
				cmd_run = (term_fwd || term_rev) && !estop;
				cmd_rev = term_rev;
			end
			DCS_RS_COMM: begin
				cmd_run = i_comm_run;
				cmd_rev = i_comm_reverse;
			end
			DCS_RS_EXP: begin
			end
		endcase
	end

	// Both jog inputs on cancel each other, as for run in forward/reverse terminal mode
	assign jog_now = (j_fwd ^ j_rev) && !estop;
	assign want_rev = jog_now ? j_rev : cmd_rev;
	assign next_run = (jog_now || cmd_run) && !(i_reverse_prohibit && want_rev);

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_run <= 1'b0;
			o_reverse <= 1'b0;
			o_jog_active <= 1'b0;
			o_emergency_stop <= 1'b0;
			o_accel_set_two <= 1'b0;
		end else begin
			o_run <= next_run;
			o_reverse <= next_run && want_rev;
			o_jog_active <= jog_now;
			o_emergency_stop <= estop;
			o_accel_set_two <= t_acc2 && !jog_now;
		end
	end

	always_comb begin
		unique case (frq_src)
			DCS_FS_KEY_UPDN: ref_sel = i_ref_keypad;
			DCS_FS_KEY_POT: ref_sel = i_ref_pot;
			DCS_FS_ANALOG: ref_sel = i_ref_analog;
			DCS_FS_TERM_UPDN: ref_sel = i_ref_updown;
			DCS_FS_COMM: ref_sel = i_ref_comm;
			default: ref_sel = `DCS_FREQ_ZERO;
		endcase
	end

	assign jog_eff = (i_jog_frequency < `DCS_JOG_MIN) ? `DCS_JOG_MIN :
		(i_jog_frequency > `DCS_JOG_MAX) ? `DCS_JOG_MAX : i_jog_frequency;
	assign jog_acc_eff = (i_jog_accel_time < `DCS_JOG_T_MIN) ? `DCS_JOG_T_MIN
		: i_jog_accel_time;
	assign jog_dec_eff = (i_jog_decel_time < `DCS_JOG_T_MIN) ? `DCS_JOG_T_MIN
		: i_jog_decel_time;
	// Preset table governs once any preset bit is assigned, even with all bits off
	assign next_freq_req = jog_now ? jog_eff :
		(|preset_used) ? i_preset_freqs[preset_on] : ref_sel;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			u_lim_if.freq_req <= `DCS_FREQ_ZERO;
			u_lim_if.upper <= `DCS_UPPER_MAX;
			u_lim_if.lower <= `DCS_FREQ_ZERO;
			u_lim_if.rated <= `DCS_FREQ_ZERO;
			u_lim_if.base_acc <= `DCS_TIME_ZERO;
			u_lim_if.base_dec <= `DCS_TIME_ZERO;
		end else begin
			u_lim_if.freq_req <= next_freq_req;
			u_lim_if.upper <= i_freq_upper_limit;
			u_lim_if.lower <= i_freq_lower_limit;
			u_lim_if.rated <= i_motor_rated_freq;
			if (jog_now) begin
				u_lim_if.base_acc <= dcs_time_t'(jog_acc_eff);
				u_lim_if.base_dec <= dcs_time_t'(jog_dec_eff);
			end else if (t_acc2) begin
				u_lim_if.base_acc <= i_accel_time_two;
				u_lim_if.base_dec <= i_decel_time_two;
			end else begin
				u_lim_if.base_acc <= i_accel_time_one;
				u_lim_if.base_dec <= i_decel_time_one;
			end
		end
	end

	dcs_freq_limit u_freq_limit (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.lim(u_lim_if.lim)
	);

	assign o_freq_cmd = u_lim_if.freq_out;
	assign o_zero_stop = u_lim_if.zero_stop;
	assign o_accel_ramp = u_lim_if.acc_time;
	assign o_decel_ramp = u_lim_if.dec_time;

	// An out-of-range pattern keeps the last legal one
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_vector_mode <= 1'b0;
			o_vhz_pattern <= `DCS_VHZ_RST;
			o_vhz_custom <= 1'b0;
			o_run_source <= DCS_RS_KEYPAD;
			o_freq_source <= DCS_FS_KEY_UPDN;
			o_cfg_error <= 1'b0;
		end else begin
			o_vector_mode <= i_control_mode_sel == `DCS_CM_VECTOR;
			if (i_vhz_pattern_sel <= `DCS_VHZ_CUSTOM) begin
				o_vhz_pattern <= i_vhz_pattern_sel;
				o_vhz_custom <= i_vhz_pattern_sel == `DCS_VHZ_CUSTOM;
			end
			o_run_source <= run_src;
			o_freq_source <= frq_src;
			o_cfg_error <= (|code_bad) || i_vhz_pattern_sel > `DCS_VHZ_CUSTOM ||
				i_main_freq_source > `DCS_FS_LAST || i_alt_freq_source > `DCS_FS_LAST ||
				i_terminal_op_mode == `DCS_TM_ILLEGAL;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_jog_req;
		jog_now ##1 (o_jog_active && u_lim_if.freq_req == $past(jog_eff));
	endsequence
	sequence s_key_stop;
		run_src == DCS_RS_TERM && i_key_stop;
	endsequence

	chk_sync_delay: assert property (term_sync == $past(i_terminals, 2))
		else $error("terminal synchroniser delay wrong");
	chk_exp_no_run: assert property ((run_src == DCS_RS_EXP && !jog_now) |=> !o_run)
		else $error("reserved run source produced a run");
	chk_key_estop: assert property ((s_key_stop ##1 run_src == DCS_RS_TERM)
		|=> (o_emergency_stop && !o_run))
		else $error("stop key ignored under terminal control");
	chk_both_stop: assert property ((run_src == DCS_RS_TERM && t_fwd && t_rev && !jog_now &&
		i_terminal_op_mode == DCS_TM_FWD_REV) |=> !o_run)
		else $error("forward and reverse together did not stop");
	chk_rev_block: assert property ((i_reverse_prohibit && want_rev) |=> !o_run)
		else $error("reverse run while prohibited");
	chk_jog_first: assert property (jog_now |-> s_jog_req)
		else $error("jog did not take the frequency reference");
	chk_acc_set_two: assert property ((t_acc2 && !jog_now)
		|=> u_lim_if.base_acc == $past(i_accel_time_two) && o_accel_set_two)
		else $error("second ramp set not selected");
	chk_counter_slot: assert property ((i_input_function_codes[0] == `DCS_FN_COUNTER)
		|=> o_cfg_error)
		else $error("counter code on first terminal not flagged");
	chk_alt_run_src: assert property ((run_sel_used && !run_sel_on)
		|=> o_run_source == $past(i_alt_run_source))
		else $error("alternative run source not applied");
	chk_vector_mode: assert property ((i_control_mode_sel == `DCS_CM_VECTOR)
		|=> o_vector_mode)
		else $error("vector mode not reported");
endmodule
`default_nettype wire

//--- src/dcs_drive_regs.svh
// Named codes, limits and reset values of the drive command selector
`ifndef DCS_DRIVE_REGS_SVH
`define DCS_DRIVE_REGS_SVH

`define DCS_FN_FWD 5'h00
`define DCS_FN_REV 5'h01
`define DCS_FN_PRESET0 5'h02
`define DCS_FN_JOG_FWD 5'h06
`define DCS_FN_JOG_REV 5'h07
`define DCS_FN_ACC_SET2 5'h08
`define DCS_FN_RUN_SRC 5'h0d
`define DCS_FN_FRQ_SRC 5'h11
`define DCS_FN_COUNTER 5'h1c
`define DCS_FN_LIMIT 5'h1d

`define DCS_PRESET_BITS 4
`define DCS_PRESETS 16
`define DCS_3W_TERMS 3
`define DCS_3W_RUN_T 0
`define DCS_3W_STOP_T 1
`define DCS_3W_DIR_T 2
`define DCS_TM_ILLEGAL 2'h3
`define DCS_FS_LAST 3'h4

`define DCS_VHZ_CUSTOM 5'h12
`define DCS_VHZ_RST 5'h00
`define DCS_CM_VECTOR 1'b1

`define DCS_UPPER_MIN 16'h0001
`define DCS_UPPER_MAX 16'h9c40
`define DCS_LOWER_MAX 16'h9c3f
`define DCS_JOG_MIN 16'h0064
`define DCS_JOG_MAX 16'h09c4
`define DCS_JOG_T_MIN 8'h01
`define DCS_FREQ_ZERO 16'h0000
`define DCS_TIME_ZERO 16'h0000
`define DCS_TIME_SAT 16'hffff

`endif

//--- src/dcs_freq_limit.sv
// Frequency bounding and ramp duration scaling
`timescale 1ns/100ps
`default_nettype none
`include "dcs_drive_regs.svh"
module dcs_freq_limit (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Request and result
	dcs_lim_if.lim lim
);
	import dcs_pkg::*;

	dcs_freq_t upper_eff;
	dcs_freq_t lower_eff;
	dcs_freq_t next_freq;
	logic next_zero;

	// Duration scales with target over rated; a zero rating passes the base time
	function automatic dcs_time_t ramp_scale(input dcs_time_t base, input dcs_freq_t f,
		input dcs_freq_t rated);
		logic [31:0] q;
		q = 32'(base) * 32'(f);
		if (rated == `DCS_FREQ_ZERO) begin
			return base;
		end
		q = q / 32'(rated);
		return (q > 32'(`DCS_TIME_SAT)) ? `DCS_TIME_SAT : q[15:0];
	endfunction

	// Settings outside their range are pulled to the nearest legal value
	assign upper_eff = (lim.upper < `DCS_UPPER_MIN) ? `DCS_UPPER_MIN :
		(lim.upper > `DCS_UPPER_MAX) ? `DCS_UPPER_MAX : lim.upper;
	assign lower_eff = (lim.lower > `DCS_LOWER_MAX) ? `DCS_LOWER_MAX : lim.lower;

	always_comb begin
		next_zero = 1'b0;
		next_freq = lim.freq_req;
		if (lower_eff == `DCS_FREQ_ZERO && lim.freq_req == `DCS_FREQ_ZERO) begin
			next_zero = 1'b1;
		end else if (lim.freq_req <= lower_eff) begin
			next_freq = lower_eff;
		end
		if (next_freq > upper_eff) begin
			next_freq = upper_eff;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			lim.freq_out <= `DCS_FREQ_ZERO;
			lim.zero_stop <= 1'b1;
		end else begin
			lim.freq_out <= next_freq;
			lim.zero_stop <= next_zero;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			lim.acc_time <= `DCS_TIME_ZERO;
			lim.dec_time <= `DCS_TIME_ZERO;
		end else begin
			lim.acc_time <= ramp_scale(lim.base_acc, next_freq, lim.rated);
			lim.dec_time <= ramp_scale(lim.base_dec, next_freq, lim.rated);
		end
	end

	chk_upper_bound: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		1'b1 |=> lim.freq_out <= $past(upper_eff))
		else $error("output frequency above upper limit");
	chk_zero_stop: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(lower_eff == `DCS_FREQ_ZERO && lim.freq_req == `DCS_FREQ_ZERO)
		|=> lim.zero_stop && lim.freq_out == `DCS_FREQ_ZERO)
		else $error("zero command did not stop at zero speed");
	chk_lower_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(lower_eff != `DCS_FREQ_ZERO && lim.freq_req <= lower_eff && lower_eff <= upper_eff)
		|=> lim.freq_out == $past(lower_eff))
		else $error("low command not raised to lower limit");
	chk_ramp_base: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(lim.rated == next_freq && lim.rated != `DCS_FREQ_ZERO)
		|=> lim.acc_time == $past(lim.base_acc))
		else $error("ramp at rated frequency differs from base time");
endmodule
`default_nettype wire

//--- src/dcs_lim_if.sv
// Carrier between the selector and the frequency limiter
`timescale 1ns/100ps
`default_nettype none
interface dcs_lim_if;
	import dcs_pkg::*;
	dcs_freq_t freq_req;
	dcs_freq_t upper;
	dcs_freq_t lower;
	dcs_freq_t rated;
	dcs_time_t base_acc;
	dcs_time_t base_dec;
	dcs_freq_t freq_out;
	logic zero_stop;
	dcs_time_t acc_time;
	dcs_time_t dec_time;
	modport src(output freq_req, upper, lower, rated, base_acc, base_dec,
		input freq_out, zero_stop, acc_time, dec_time);
	modport lim(input freq_req, upper, lower, rated, base_acc, base_dec,
		output freq_out, zero_stop, acc_time, dec_time);
endinterface
`default_nettype wire

//--- src/dcs_pkg.sv
// Types shared by the drive command selector
package dcs_pkg;
	typedef logic [15:0] dcs_freq_t;
	typedef logic [15:0] dcs_time_t;
	typedef enum logic [1:0] {
		DCS_RS_KEYPAD = 2'b00,
		DCS_RS_TERM = 2'b01,
		DCS_RS_COMM = 2'b10,
		DCS_RS_EXP = 2'b11
	} dcs_run_src_e;
	typedef enum logic [2:0] {
		DCS_FS_KEY_UPDN = 3'b000,
		DCS_FS_KEY_POT = 3'b001,
		DCS_FS_ANALOG = 3'b010,
		DCS_FS_TERM_UPDN = 3'b011,
		DCS_FS_COMM = 3'b100
	} dcs_freq_src_e;
	typedef enum logic [1:0] {
		DCS_TM_FWD_REV = 2'b00,
		DCS_TM_RUN_DIR = 2'b01,
		DCS_TM_THREE_WIRE = 2'b10
	} dcs_term_mode_e;
	typedef enum logic {
		DCS_LT_STOP = 1'b0,
		DCS_LT_RUN = 1'b1
	} dcs_latch_e;
endpackage

//--- tb/dcs_partner.sv
// Terminal contact model facing the selector's raw inputs
`timescale 1ns/100ps
`default_nettype none
module dcs_partner (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Wanted and actual contact levels
	input wire logic [5:0] i_want,
	output logic [5:0] o_contacts
);
	// Contacts change only after a clock edge, never mid-cycle
	always @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_contacts <= 6'h00;
		end else begin
			o_contacts <= i_want;
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench of the drive command selector
`timescale 1ns/100ps
`default_nettype none
`include "dcs_drive_regs.svh"
module tb_top;
	import dcs_pkg::*;
	typedef struct {int sel; logic [15:0] exp;} dcs_note_s;
	logic clk, rst, msel, krun, kstop, prohib;
	logic [4:0] vhz;
	logic [1:0] tmode;
	logic [5:0] want, terms;
	logic [5:0][4:0] codes;
	dcs_run_src_e msrc;
	dcs_freq_t up, lo, kref, jogf;
	dcs_freq_t [15:0] pre;
	dcs_freq_t r5 [5];
	logic [15:0] rnd;
	logic o_vm, o_vc, o_run, o_rev, o_zs, o_es;
	logic o_ce, o_ja, o_a2;
	logic [4:0] o_vp;
	logic [2:0] o_fs;
	dcs_run_src_e o_rs;
	dcs_freq_t o_fc;
	dcs_time_t o_ar, o_dr;
	dcs_note_s q[$];
	dcs_note_s nt;
	int n_fail, cmp_count, e;
	string nm [15] = '{"run", "reverse", "freq_cmd", "zero_stop", "accel_ramp",
		"vector_mode", "vhz_custom", "run_source", "emergency_stop", "cfg_error",
		"jog_active", "accel_set_two", "vhz_pattern", "freq_source", "decel_ramp"};
	dcs_partner u_dcs_partner (.i_ref_clk(clk), .i_sys_rst(rst), .i_want(want),
		.o_contacts(terms));
	dcs_cmd_select u_dcs_cmd_select (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_control_mode_sel(msel), .i_vhz_pattern_sel(vhz), .i_main_run_source(msrc),
		.i_alt_run_source(dcs_run_src_e'(rnd[1:0])), .i_main_freq_source(3'h0),
		.i_alt_freq_source(rnd[4:2]), .i_freq_upper_limit(up), .i_freq_lower_limit(lo),
		.i_motor_rated_freq(16'h1388), .i_accel_time_one(16'h0064),
		.i_decel_time_one(r5[0]), .i_accel_time_two(r5[1]), .i_decel_time_two(r5[2]),
		.i_jog_frequency(jogf), .i_jog_accel_time(r5[3][7:0]),
		.i_jog_decel_time(r5[4][7:0]), .i_terminal_op_mode(tmode),
		.i_reverse_prohibit(prohib), .i_input_function_codes(codes), .i_terminals(terms),
		.i_key_run(krun), .i_key_stop(kstop), .i_key_reverse(rnd[5]),
		.i_comm_run(rnd[6]), .i_comm_reverse(rnd[7]), .i_ref_keypad(kref),
		.i_ref_pot(r5[0]), .i_ref_analog(r5[1]), .i_ref_updown(r5[2]),
		.i_ref_comm(r5[3]), .i_preset_freqs(pre), .o_vector_mode(o_vm),
		.o_vhz_pattern(o_vp), .o_vhz_custom(o_vc), .o_cfg_error(o_ce), .o_run_source(o_rs),
		.o_freq_source(o_fs), .o_run(o_run), .o_reverse(o_rev), .o_jog_active(o_ja),
		.o_emergency_stop(o_es), .o_accel_set_two(o_a2), .o_freq_cmd(o_fc),
		.o_zero_stop(o_zs), .o_accel_ramp(o_ar), .o_decel_ramp(o_dr));
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [15:0] obs(int s);
		case (s)
			0: return 16'(o_run);
			1: return 16'(o_rev);
			2: return o_fc;
			3: return 16'(o_zs);
			4: return o_ar;
			5: return 16'(o_vm);
			6: return 16'(o_vc);
			7: return 16'(o_rs);
			8: return 16'(o_es);
			9: return 16'(o_ce);
			10: return 16'(o_ja);
			11: return 16'(o_a2);
			12: return 16'(o_vp);
			13: return 16'(o_fs);
			default: return o_dr;
		endcase
	endfunction
	task automatic check(int s, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm[s], exp, seen);
		end
	endtask
	task automatic note(int s, logic [15:0] x);
		q.push_back('{s, x});
	endtask
	task automatic edges(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Results are read on the falling edge, well after the launching edge settles
	always @(negedge clk) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			check(nt.sel, obs(nt.sel), nt.exp);
		end
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#40000;
		n_fail++;
		end_of_test();
	end
	initial begin
		rst = 1'b1; msel = 1'b0; vhz = 5'h00; msrc = DCS_RS_KEYPAD; up = 16'h2710;
		lo = 16'h03e8; kref = 16'h0000; jogf = 16'h07d0; tmode = 2'h0; prohib = 1'b0;
		krun = 1'b0; kstop = 1'b0; want = 6'h00; rnd = 16'h0034;
		// Unused terminals get a reserved code so no preset or source switch is assigned
		codes = {5'h18, 5'h18, 5'h18, `DCS_FN_JOG_FWD, `DCS_FN_REV, `DCS_FN_FWD};
		for (int i = 0; i < 16; i++) pre[i] = 16'(i * 16'h0100);
		for (int i = 0; i < 5; i++) r5[i] = 16'h0010 + 16'(i);
		edges(6);
		rst <= 1'b0;
		edges(1);
		msel <= 1'b1; vhz <= `DCS_VHZ_CUSTOM; krun <= 1'b1;
		edges(1);
		krun <= 1'b0;
		edges(2);
		note(5, 16'h0001);
		note(6, 16'h0001);
		note(12, 16'h0012);
		note(0, 16'h0001);
		kstop <= 1'b1;
		edges(1);
		kstop <= 1'b0;
		edges(2);
		note(0, 16'h0000);
		$display("test modes_keypad done");
		for (int k = 0; k < 6; k++) begin
			rnd <= lfsr(rnd);
			kref <= (k == 0) ? 16'h0000 : (k == 1) ? 16'h03e8 : 16'(rnd % 16'h3a98);
			lo <= (k == 0) ? 16'h0000 : 16'h03e8;
			edges(4);
			e = (k == 0) ? 0 : (kref <= lo) ? lo : (kref > up) ? up : kref;
			note(2, 16'(e));
			note(3, (k == 0) ? 16'h0001 : 16'h0000);
			note(4, 16'((e * 100) / 5000));
		end
		$display("test limits done");
		msrc <= DCS_RS_TERM;
		want <= 6'h01;
		edges(7);
		note(0, 16'h0001);
		note(1, 16'h0000);
		note(7, 16'h0001);
		want <= 6'h03;
		edges(7);
		note(0, 16'h0000);
		want <= 6'h02; prohib <= 1'b1;
		edges(7);
		note(0, 16'h0000);
		want <= 6'h01; prohib <= 1'b0;
		edges(7);
		kstop <= 1'b1;
		edges(3);
		note(8, 16'h0001);
		note(0, 16'h0000);
		kstop <= 1'b0; want <= 6'h00;
		edges(7);
		$display("test terminals done");
		want <= 6'h04;
		edges(8);
		note(2, jogf);
		note(10, 16'h0001);
		want <= 6'h00; msrc <= DCS_RS_EXP; krun <= 1'b1;
		// Jog needs the synchroniser to drain before the run drops
		edges(5);
		note(0, 16'h0000);
		krun <= 1'b0;
		edges(3);
		$display("test jog_reserved done");
		msrc <= DCS_RS_TERM; want <= 6'h19;
		codes <= {5'h1d, 5'h05, `DCS_FN_ACC_SET2, `DCS_FN_JOG_FWD, `DCS_FN_REV,
			`DCS_FN_FWD};
		edges(7);
		note(0, 16'h0001);
		note(9, 16'h0000);
		note(11, 16'h0001);
		note(2, 16'h0800);
		note(4, 16'((17 * 2048) / 5000));
		note(14, 16'((18 * 2048) / 5000));
		codes[0] <= `DCS_FN_COUNTER;
		edges(2);
		note(9, 16'h0001);
		note(0, 16'h0000);
		$display("test functions done");
		tmode <= 2'h2; want <= 6'h02;
		codes <= {5'h18, 5'h18, 5'h18, `DCS_FN_JOG_FWD, `DCS_FN_REV, `DCS_FN_FWD};
		edges(5);
		want <= 6'h03;
		edges(1);
		want <= 6'h02;
		edges(6);
		note(0, 16'h0001);
		note(1, 16'h0000);
		want <= 6'h06;
		edges(5);
		note(1, 16'h0001);
		note(10, 16'h0000);
		want <= 6'h04;
		edges(6);
		note(0, 16'h0000);
		$display("test three_wire done");
		tmode <= 2'h0; want <= 6'h00;
		codes <= {`DCS_FN_RUN_SRC, `DCS_FN_FRQ_SRC, 5'h18, `DCS_FN_JOG_FWD, `DCS_FN_REV,
			`DCS_FN_FWD};
		edges(6);
		note(7, 16'(rnd[1:0]));
		note(13, 16'(rnd[4:2]));
		want <= 6'h30;
		edges(5);
		note(7, 16'h0001);
		note(13, 16'h0000);
		$display("test source_select done");
		end_of_test();
	end
endmodule
`default_nettype wire
